// ---- core/rrse_map.svh ----
// Constants for the return, rotate, sleep and subtract execution slice
`ifndef RRSE_MAP_SVH
`define RRSE_MAP_SVH

// Opcode patterns (top bits compared under mask)
`define RRSE_OP_RETI        16'h0010
`define RRSE_MSK_RETI       16'hfffe
`define RRSE_OP_RETS        16'h0012
`define RRSE_MSK_RETS       16'hfffe
`define RRSE_OP_SLEEP       16'h0003
`define RRSE_MSK_FULL       16'hffff
`define RRSE_OP_RETLIT      16'h0c00
`define RRSE_MSK_HIBYTE     16'hff00
`define RRSE_OP_RLC         16'h3400
`define RRSE_OP_RRC         16'h3000
`define RRSE_OP_RLN         16'h4400
`define RRSE_OP_RRN         16'h4000
`define RRSE_MSK_ROT        16'hfc00
`define RRSE_OP_FILL        16'h6800
`define RRSE_MSK_FILL       16'hfe00
`define RRSE_OP_SUBB        16'h5400
`define RRSE_MSK_SUBB       16'hfc00

// Instruction field positions
`define RRSE_BIT_SHADOW     0
`define RRSE_BIT_DEST       9
`define RRSE_BIT_ACCESS     8

// Indexed literal-offset window upper limit
`define RRSE_IDX_LIMIT      8'h5f
`define RRSE_FILL_VALUE     8'hff
`define RRSE_WDT_CLEAR      8'h00

// Status register bit positions
`define RRSE_ST_C           0
`define RRSE_ST_DC          1
`define RRSE_ST_Z           2
`define RRSE_ST_OV          3
`define RRSE_ST_N           4

`endif

// ---- core/rrse_pkg.sv ----
// Types for the return, rotate, sleep and subtract execution slice
package rrse_pkg;

	typedef enum logic [3:0] {
		RRSE_OP_NONE,
		RRSE_OP_RET_IRQ,
		RRSE_OP_RET_SUB,
		RRSE_OP_RET_LIT,
		RRSE_OP_ROT_LC,
		RRSE_OP_ROT_LN,
		RRSE_OP_ROT_RC,
		RRSE_OP_ROT_RN,
		RRSE_OP_FILL,
		RRSE_OP_SLEEP,
		RRSE_OP_SUBB
	} rrse_op_t;

endpackage : rrse_pkg

// ---- core/rrse_decode.sv ----
// Opcode classifier for the return, rotate, sleep and subtract slice
`include "rrse_map.svh"
`timescale 1ns/1ns
`default_nettype none

module rrse_decode (
	input  wire logic [15:0]       instr,
	output rrse_pkg::rrse_op_t     op
);

	function automatic logic hit(input logic [15:0] w, input logic [15:0] pat,
			input logic [15:0] msk);
		hit = ((w & msk) == pat);
	endfunction : hit

	always_comb begin
		op = rrse_pkg::RRSE_OP_NONE;
		if (hit(instr, `RRSE_OP_RETI, `RRSE_MSK_RETI))
			op = rrse_pkg::RRSE_OP_RET_IRQ;
		else if (hit(instr, `RRSE_OP_RETS, `RRSE_MSK_RETS))
			op = rrse_pkg::RRSE_OP_RET_SUB;
		else if (hit(instr, `RRSE_OP_SLEEP, `RRSE_MSK_FULL))
			op = rrse_pkg::RRSE_OP_SLEEP;
		else if (hit(instr, `RRSE_OP_RETLIT, `RRSE_MSK_HIBYTE))
			op = rrse_pkg::RRSE_OP_RET_LIT;
		else if (hit(instr, `RRSE_OP_RLC, `RRSE_MSK_ROT))
			op = rrse_pkg::RRSE_OP_ROT_LC;
		else if (hit(instr, `RRSE_OP_RLN, `RRSE_MSK_ROT))
			op = rrse_pkg::RRSE_OP_ROT_LN;
		else if (hit(instr, `RRSE_OP_RRC, `RRSE_MSK_ROT))
			op = rrse_pkg::RRSE_OP_ROT_RC;
		else if (hit(instr, `RRSE_OP_RRN, `RRSE_MSK_ROT))
			op = rrse_pkg::RRSE_OP_ROT_RN;
		else if (hit(instr, `RRSE_OP_FILL, `RRSE_MSK_FILL))
			op = rrse_pkg::RRSE_OP_FILL;
		else if (hit(instr, `RRSE_OP_SUBB, `RRSE_MSK_SUBB))
			op = rrse_pkg::RRSE_OP_SUBB;
	end

endmodule : rrse_decode

`default_nettype wire

// ---- core/rrse_alu.sv ----
// Byte arithmetic for rotates and subtract-with-borrow
`include "rrse_map.svh"
`timescale 1ns/1ns
`default_nettype none

module rrse_alu (
	input  wire logic [7:0]        acc,
	input  wire logic [7:0]        opnd,
	input  wire logic [4:0]        flags_in,
	input  var  rrse_pkg::rrse_op_t op,
	output logic      [7:0]        result,
	output logic      [4:0]        flags_out
);

	logic       c_in;
	logic [8:0] diff;
	logic [4:0] nib;

	assign c_in = flags_in[`RRSE_ST_C];

	always_comb begin
		result    = opnd;
		flags_out = flags_in;
		diff      = 9'h000;
		nib       = 5'h00;
		case (op)
			rrse_pkg::RRSE_OP_ROT_LC: begin
				result = {opnd[6:0], c_in};
				flags_out[`RRSE_ST_C] = opnd[7];
			end
			rrse_pkg::RRSE_OP_ROT_LN: result = {opnd[6:0], opnd[7]};
			rrse_pkg::RRSE_OP_ROT_RC: begin
				result = {c_in, opnd[7:1]};
				flags_out[`RRSE_ST_C] = opnd[0];
			end
			rrse_pkg::RRSE_OP_ROT_RN: result = {opnd[0], opnd[7:1]};
			rrse_pkg::RRSE_OP_SUBB: begin
				// Carry set means no borrow: acc + ~f + c
				diff   = {1'b0, acc} + {1'b0, ~opnd} + {8'h00, c_in};
				nib    = {1'b0, acc[3:0]} + {1'b0, ~opnd[3:0]} + {4'h0, c_in};
				result = diff[7:0];
				flags_out[`RRSE_ST_C]  = diff[8];
				flags_out[`RRSE_ST_DC] = nib[4];
				flags_out[`RRSE_ST_OV] = (acc[7] != opnd[7]) && (diff[7] != acc[7]);
			end
			default: result = opnd;
		endcase
		flags_out[`RRSE_ST_N] = result[7];
		flags_out[`RRSE_ST_Z] = (result == 8'h00);
	end

endmodule : rrse_alu

`default_nettype wire

// ---- core/rrse_exec.sv ----
// Execution slice: returns, rotates, fill, sleep, subtract-with-borrow
//
// Functional notes
// - Interrupt return pops stack into program counter, two cycles, second idle.
// - Interrupt return sets high or low global enable in last quarter.
// - Shadow bit set reloads accumulator, flags, bank selector from shadows.
// - Subroutine return pops stack in quarter four, two cycles, no flags unless shadow bit set.
// - Returns never touch the upper and high program counter latches.
// - Literal return loads immediate to accumulator and pops stack, two cycles.
// - Left rotate via carry: bit 7 to carry, carry to bit 0; C,N,Z.
// - Left rotate without carry wraps bit 7 to bit 0; N,Z only.
// - Right rotate via carry: bit 0 to carry, carry to bit 7; C,N,Z.
// - Right rotate without carry wraps bit 0 to bit 7; N,Z only.
// - Destination bit 0 writes accumulator, 1 writes the file register.
// - Access bit 0 uses access bank, 1 uses the bank selector.
// - Extended set with access bit 0 indexes addresses up to 95.
// - Fill writes FFh to the file register in one cycle, flags unchanged.
// - Sleep sets the time-out flag and clears the power-down flag.
// - Sleep clears watchdog and postscaler, then stops oscillator in quarter four.
// - Watchdog wake-up from sleep leaves the time-out flag cleared.
// - Subtract-with-borrow: acc minus file minus borrow; N,OV,C,DC,Z; to dest.
`include "rrse_map.svh"
`timescale 1ns/1ns
`default_nettype none

module rrse_exec #(
	parameter int ADDR_W = 12
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_b,
	input  wire logic              instr_valid,
	input  wire logic [15:0]       instr,
	input  wire logic              ext_set_en,
	input  wire logic              irq_high_active,
	input  wire logic [7:0]        file_rdata,
	input  wire logic [20:0]       stack_top,
	input  wire logic [7:0]        accumulator_shadow,
	input  wire logic [4:0]        flags_shadow,
	input  wire logic [3:0]        bank_selector_shadow,
	input  wire logic [7:0]        index_base,
	input  wire logic              wdt_wake,
	input  wire logic              wake,
	output logic      [1:0]        quarter,
	output logic                   instr_ack,
	output logic                   busy,
	output logic [ADDR_W-1:0]      file_addr,
	output logic                   file_rd,
	output logic                   file_wr,
	output logic      [7:0]        file_wdata,
	output logic                   stack_pop,
	output logic      [20:0]       pc_q,
	output logic                   pc_load,
	output logic                   flush_fetch,
	output logic      [7:0]        acc_q,
	output logic      [4:0]        flags_q,
	output logic      [3:0]        bank_selector_q,
	output logic                   high_priority_global_irq_enable_q,
	output logic                   low_priority_global_irq_enable_q,
	output logic                   timeout_flag_q,
	output logic                   power_down_flag_q,
	output logic                   wdt_clear,
	output logic                   osc_stop,
	output logic                   sleeping_q
);

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	rrse_pkg::rrse_op_t op_now;
	rrse_pkg::rrse_op_t op_q, op_d;
	logic [15:0]        ins_q, ins_d;

	rrse_decode u_dec (
		.instr (instr),
		.op    (op_now)
	);

	// ---------------------------------------------------------------
	// Quarter sequencer
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {RRSE_ST_RUN, RRSE_ST_IDLE, RRSE_ST_SLEEP} rrse_state_t;

	rrse_state_t st_q, st_d;
	logic [1:0]  qtr_q, qtr_d;
	logic [7:0]  opnd_q, opnd_d;
	logic [7:0]  alu_res;
	logic [4:0]  alu_flags;
	logic [20:0] pc_d;
	logic [7:0]  acc_d;
	logic [4:0]  flags_d;
	logic [3:0]  bsel_d;
	logic        high_priority_global_irq_enable_d, low_priority_global_irq_enable_d, to_d, pd_d, slp_d;
	logic        ins_dest, ins_acc, ins_shadow, is_file_op, is_return;

	rrse_alu u_alu (
		.acc       (acc_q),
		.opnd      (opnd_q),
		.flags_in  (flags_q),
		.op        (op_q),
		.result    (alu_res),
		.flags_out (alu_flags)
	);

	function automatic logic [ADDR_W-1:0] eff_addr(input logic [7:0] f, input logic a,
			input logic ext, input logic [3:0] bsel, input logic [7:0] base);
		logic [ADDR_W-1:0] r;
		r = '0;
		if (a)
			r = ADDR_W'({bsel, f});
		else if (ext && f <= `RRSE_IDX_LIMIT)
			r = ADDR_W'({4'h0, base} + {4'h0, f});
		else if (f[7])
			r = ADDR_W'({4'hf, f});
		else
			r = ADDR_W'({4'h0, f});
		eff_addr = r;
	endfunction : eff_addr

	assign ins_dest   = ins_q[`RRSE_BIT_DEST];
	assign ins_acc    = ins_q[`RRSE_BIT_ACCESS];
	assign ins_shadow = ins_q[`RRSE_BIT_SHADOW];
	assign is_return  = (op_q == rrse_pkg::RRSE_OP_RET_IRQ) ||
			(op_q == rrse_pkg::RRSE_OP_RET_SUB) || (op_q == rrse_pkg::RRSE_OP_RET_LIT);
	assign is_file_op = (op_q == rrse_pkg::RRSE_OP_ROT_LC) ||
			(op_q == rrse_pkg::RRSE_OP_ROT_LN) || (op_q == rrse_pkg::RRSE_OP_ROT_RC) ||
			(op_q == rrse_pkg::RRSE_OP_ROT_RN) || (op_q == rrse_pkg::RRSE_OP_SUBB) ||
			(op_q == rrse_pkg::RRSE_OP_FILL);

	always_comb begin
		st_d        = st_q;
		qtr_d       = qtr_q;
		op_d        = op_q;
		ins_d       = ins_q;
		opnd_d      = opnd_q;
		pc_d        = pc_q;
		acc_d       = acc_q;
		flags_d     = flags_q;
		bsel_d      = bank_selector_q;
		high_priority_global_irq_enable_d      = high_priority_global_irq_enable_q;
		low_priority_global_irq_enable_d      = low_priority_global_irq_enable_q;
		to_d        = timeout_flag_q;
		pd_d        = power_down_flag_q;
		slp_d       = sleeping_q;
		instr_ack   = 1'b0;
		file_rd     = 1'b0;
		file_wr     = 1'b0;
		file_wdata  = alu_res;
		stack_pop   = 1'b0;
		pc_load     = 1'b0;
		flush_fetch = 1'b0;
		wdt_clear   = 1'b0;
		osc_stop    = 1'b0;
		file_addr   = eff_addr(ins_q[7:0], ins_acc, ext_set_en, bank_selector_q, index_base);
		case (st_q)
			RRSE_ST_RUN: begin
				qtr_d = qtr_q + 2'd1;
				case (qtr_q)
					2'd0: begin
						// Q1: take and decode the instruction
						if (instr_valid) begin
							instr_ack = 1'b1;
							op_d      = op_now;
							ins_d     = instr;
						end else begin
							op_d = rrse_pkg::RRSE_OP_NONE;
						end
					end
					2'd1: begin
						if (is_file_op) begin
							file_rd = 1'b1;
							opnd_d  = file_rdata;
						end
					end
					2'd2: begin
						if (op_q == rrse_pkg::RRSE_OP_SLEEP) begin
							wdt_clear = 1'b1;
							to_d      = 1'b1;
							pd_d      = 1'b0;
						end
					end
					default: begin
						// Q4: write-back; returns pop only here
						case (op_q)
							rrse_pkg::RRSE_OP_ROT_LC, rrse_pkg::RRSE_OP_ROT_LN,
							rrse_pkg::RRSE_OP_ROT_RC, rrse_pkg::RRSE_OP_ROT_RN,
							rrse_pkg::RRSE_OP_SUBB: begin
								flags_d = alu_flags;
								if (ins_dest)
									file_wr = 1'b1;
								else
									acc_d = alu_res;
							end
							rrse_pkg::RRSE_OP_FILL: begin
								file_wr    = 1'b1;
								file_wdata = `RRSE_FILL_VALUE;
							end
							rrse_pkg::RRSE_OP_SLEEP: begin
								osc_stop = 1'b1;
								slp_d    = 1'b1;
								st_d     = RRSE_ST_SLEEP;
							end
							default: begin
							end
						endcase
						if (is_return) begin
							// Latches are not ports here, so they stay untouched
							stack_pop   = 1'b1;
							pc_load     = 1'b1;
							pc_d        = stack_top;
							flush_fetch = 1'b1;
							st_d        = RRSE_ST_IDLE;
							if (op_q == rrse_pkg::RRSE_OP_RET_LIT)
								acc_d = ins_q[7:0];
							if (op_q != rrse_pkg::RRSE_OP_RET_LIT && ins_shadow) begin
								acc_d   = accumulator_shadow;
								flags_d = flags_shadow;
								bsel_d  = bank_selector_shadow;
							end
							if (op_q == rrse_pkg::RRSE_OP_RET_IRQ) begin
								if (irq_high_active)
									high_priority_global_irq_enable_d = 1'b1;
								else
									low_priority_global_irq_enable_d = 1'b1;
							end
						end
					end
				endcase
			end
			RRSE_ST_IDLE: begin
				// Second cycle does nothing; fetched word is discarded
				qtr_d = qtr_q + 2'd1;
				if (qtr_q == 2'd3) begin
					st_d = RRSE_ST_RUN;
					op_d = rrse_pkg::RRSE_OP_NONE;
				end
			end
			RRSE_ST_SLEEP: begin
				qtr_d = 2'd0;
				if (wdt_wake)
					to_d = 1'b0;
				if (wake || wdt_wake) begin
					slp_d = 1'b0;
					st_d  = RRSE_ST_RUN;
					op_d  = rrse_pkg::RRSE_OP_NONE;
				end
			end
			default: st_d = RRSE_ST_RUN;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_q                              <= RRSE_ST_RUN;
			qtr_q                             <= 2'd0;
			op_q                              <= rrse_pkg::RRSE_OP_NONE;
			ins_q                             <= 16'h0000;
			opnd_q                            <= 8'h00;
			pc_q                              <= 21'h000000;
			acc_q                             <= 8'h00;
			flags_q                           <= 5'h00;
			bank_selector_q                   <= 4'h0;
			high_priority_global_irq_enable_q <= 1'b0;
			low_priority_global_irq_enable_q  <= 1'b0;
			timeout_flag_q                    <= 1'b1;
			power_down_flag_q                 <= 1'b1;
			sleeping_q                        <= 1'b0;
		end else begin
			st_q                              <= st_d;
			qtr_q                             <= qtr_d;
			op_q                              <= op_d;
			ins_q                             <= ins_d;
			opnd_q                            <= opnd_d;
			pc_q                              <= pc_d;
			acc_q                             <= acc_d;
			flags_q                           <= flags_d;
			bank_selector_q                   <= bsel_d;
			high_priority_global_irq_enable_q <= high_priority_global_irq_enable_d;
			low_priority_global_irq_enable_q  <= low_priority_global_irq_enable_d;
			timeout_flag_q                    <= to_d;
			power_down_flag_q                 <= pd_d;
			sleeping_q                        <= slp_d;
		end
	end

	assign quarter = qtr_q;
	assign busy    = (st_q != RRSE_ST_RUN);

endmodule : rrse_exec

`default_nettype wire

// ---- verification/rrse_exec_asserts.sv ----
// Concurrent checks on the return, rotate, sleep and subtract slice
`timescale 1ns/1ns
`default_nettype none

module rrse_exec_asserts (
	input wire logic        clk_sys,
	input wire logic        rst_b,
	input wire logic [1:0]  quarter,
	input wire logic        instr_valid,
	input wire logic        instr_ack,
	input wire logic        busy,
	input wire logic        file_rd,
	input wire logic        file_wr,
	input wire logic        stack_pop,
	input wire logic        pc_load,
	input wire logic        flush_fetch,
	input wire logic [20:0] pc_q,
	input wire logic [20:0] stack_top,
	input wire logic        wdt_wake,
	input wire logic        timeout_flag_q,
	input wire logic        power_down_flag_q,
	input wire logic        wdt_clear,
	input wire logic        osc_stop,
	input wire logic        sleeping_q
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	// ----------------------------------------
	// Multi-step sequences
	// ----------------------------------------
	sequence idle_gap;
		busy [*4] ##1 !busy;
	endsequence
	sequence sleep_tail;
		osc_stop ##1 sleeping_q;
	endsequence

	ack_phase_a: assert property (instr_ack |-> quarter == 2'h0 && instr_valid && !busy)
		else $error("instruction taken outside quarter one");
	read_phase_a: assert property (file_rd |-> quarter == 2'h1)
		else $error("operand read outside quarter two");
	write_phase_a: assert property (file_wr |-> quarter == 2'h3)
		else $error("file write outside quarter four");
	return_pulses_a: assert property (stack_pop |-> pc_load && flush_fetch && quarter == 2'h3)
		else $error("stack pop without reload and flush in quarter four");
	pc_reload_a: assert property (pc_load |=> pc_q == $past(stack_top))
		else $error("counter not loaded from stack top");
	idle_gap_a: assert property (stack_pop |=> idle_gap)
		else $error("idle cycle after return missing");
	sleep_steps_a: assert property (wdt_clear |-> quarter == 2'h2 ##1 sleep_tail)
		else $error("sleep entry steps out of order");
	sleep_flags_a: assert property (wdt_clear |-> ##2 timeout_flag_q && !power_down_flag_q)
		else $error("sleep status flags wrong");
	sleep_hold_a: assert property (sleeping_q |-> busy && !instr_ack && quarter == 2'h0)
		else $error("core active while asleep");
	wdt_wake_a: assert property (sleeping_q && wdt_wake |=> !timeout_flag_q)
		else $error("time-out flag set after watchdog wake");
endmodule : rrse_exec_asserts

bind rrse_exec rrse_exec_asserts i_rrse_exec_asserts (
	.clk_sys(clk_sys), .rst_b(rst_b), .quarter(quarter), .instr_valid(instr_valid),
	.instr_ack(instr_ack), .busy(busy), .file_rd(file_rd), .file_wr(file_wr),
	.stack_pop(stack_pop), .pc_load(pc_load), .flush_fetch(flush_fetch), .pc_q(pc_q),
	.stack_top(stack_top), .wdt_wake(wdt_wake), .timeout_flag_q(timeout_flag_q),
	.power_down_flag_q(power_down_flag_q), .wdt_clear(wdt_clear), .osc_stop(osc_stop),
	.sleeping_q(sleeping_q)
);
`default_nettype wire

// ---- verification/tb_rrse_exec.sv ----
// Directed bench for the return, rotate, sleep and subtract slice
`timescale 1ns/1ns
`default_nettype none

module tb_rrse_exec;
	logic        clk_sys, rst_b, instr_valid, ext_set_en, irq_high_active, wdt_wake, wake;
	logic [15:0] instr;
	logic [7:0]  file_rdata, accumulator_shadow, index_base, file_wdata, acc_q;
	logic [20:0] stack_top, pc_q;
	logic [4:0]  flags_shadow, flags_q;
	logic [3:0]  bank_selector_shadow, bank_selector_q;
	logic [1:0]  quarter;
	logic [11:0] file_addr;
	logic        instr_ack, busy, file_rd, file_wr, stack_pop, pc_load, flush_fetch;
	logic        hi_en, lo_en, to_flag, pd_flag, wdt_clear, osc_stop, sleeping_q;
	logic [31:0] addr_s, rd_s, wr_s, wd_s, pop_s, clr_s, osc_s, idle_n;
	int          num_errors, n_checks, cyc;

	rrse_exec #(.ADDR_W(12)) i_rrse_exec (
		.clk_sys(clk_sys), .rst_b(rst_b), .instr_valid(instr_valid), .instr(instr),
		.ext_set_en(ext_set_en), .irq_high_active(irq_high_active), .file_rdata(file_rdata),
		.stack_top(stack_top), .accumulator_shadow(accumulator_shadow),
		.flags_shadow(flags_shadow), .bank_selector_shadow(bank_selector_shadow),
		.index_base(index_base), .wdt_wake(wdt_wake), .wake(wake), .quarter(quarter),
		.instr_ack(instr_ack), .busy(busy), .file_addr(file_addr), .file_rd(file_rd),
		.file_wr(file_wr), .file_wdata(file_wdata), .stack_pop(stack_pop), .pc_q(pc_q),
		.pc_load(pc_load), .flush_fetch(flush_fetch), .acc_q(acc_q), .flags_q(flags_q),
		.bank_selector_q(bank_selector_q), .high_priority_global_irq_enable_q(hi_en),
		.low_priority_global_irq_enable_q(lo_en), .timeout_flag_q(to_flag),
		.power_down_flag_q(pd_flag), .wdt_clear(wdt_clear), .osc_stop(osc_stop),
		.sleeping_q(sleeping_q)
	);

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task complete_run;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run

	// Bounded so a stuck run still reaches the verdict
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			num_errors++;
			complete_run();
		end
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// Counts cycles until the core is idle at quarter one again
	task sync;
		idle_n = 0;
		while ((busy !== 1'b0 || quarter !== 2'h0) && idle_n < 12) begin
			@(posedge clk_sys);
			#1;
			idle_n++;
		end
	endtask : sync

	task run(input logic [15:0] w, input logic [7:0] rd);
		instr_valid <= 1'b1;
		instr <= w;
		file_rdata <= rd;
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		#1;
		addr_s = file_addr;
		rd_s = file_rd;
		@(posedge clk_sys);
		#1;
		clr_s = wdt_clear;
		@(posedge clk_sys);
		#1;
		wr_s = file_wr;
		wd_s = file_wdata;
		osc_s = osc_stop;
		pop_s = {stack_pop, pc_load, flush_fetch};
		@(posedge clk_sys);
		#1;
		sync();
	endtask : run

	initial begin
		{rst_b, instr_valid, ext_set_en, irq_high_active, wdt_wake, wake} = '0;
		{instr, file_rdata, accumulator_shadow, index_base, stack_top} = '0;
		{flags_shadow, bank_selector_shadow} = '0;
		repeat (2) @(posedge clk_sys);
		rst_b <= 1'b1;
		#1;
		chk(to_flag, 1);
		chk(pd_flag, 1);
		chk(flags_q, 0);
		sync();
		$display("reset test done");
		run(16'h3410, 8'he6);
		chk(acc_q, 8'hcc);
		chk(flags_q, 5'h11);
		chk(wr_s, 0);
		chk(addr_s, 12'h010);
		chk(rd_s, 1);
		run(16'h4320, 8'hd7);
		chk(wd_s, 8'heb);
		chk(wr_s, 1);
		chk(flags_q, 5'h11);
		run(16'h3000, 8'h00);
		chk(acc_q, 8'h80);
		chk(flags_q, 5'h10);
		run(16'h4400, 8'h00);
		chk(acc_q, 8'h00);
		chk(flags_q, 5'h04);
		ext_set_en <= 1'b1;
		index_base <= 8'h10;
		run(16'h685f, 8'h5a);
		chk(addr_s, 12'h06f);
		chk(wd_s, 8'hff);
		chk(flags_q, 5'h04);
		chk(idle_n, 0);
		run(16'h5681, 8'h01);
		chk(addr_s, 12'hf81);
		chk(wd_s, 8'hfe);
		chk(flags_q, 5'h10);
		chk(acc_q, 8'h00);
		$display("rotate test done");
		stack_top <= 21'h012345;
		run(16'h0c5a, 8'h00);
		chk(acc_q, 8'h5a);
		chk(pc_q, 21'h012345);
		chk(pop_s, 3'h7);
		chk(idle_n, 4);
		{accumulator_shadow, flags_shadow, bank_selector_shadow} <= {8'ha5, 5'h0b, 4'h3};
		irq_high_active <= 1'b1;
		stack_top <= 21'h1abcd;
		run(16'h0011, 8'h00);
		chk({acc_q, flags_q, bank_selector_q}, {8'ha5, 5'h0b, 4'h3});
		chk({hi_en, lo_en}, 2'h2);
		chk(pc_q, 21'h1abcd);
		chk(idle_n, 4);
		run(16'h4710, 8'h81);
		chk(addr_s, 12'h310);
		chk(wd_s, 8'h03);
		accumulator_shadow <= 8'h3c;
		irq_high_active <= 1'b0;
		stack_top <= 21'h00abc;
		run(16'h0012, 8'h00);
		chk(acc_q, 8'ha5);
		chk(flags_q, 5'h0b);
		chk(pc_q, 21'h00abc);
		chk(lo_en, 0);
		run(16'h0010, 8'h00);
		chk(lo_en, 1);
		chk(acc_q, 8'ha5);
		$display("return test done");
		run(16'h0003, 8'h00);
		chk(clr_s, 1);
		chk(osc_s, 1);
		chk({to_flag, pd_flag}, 2'h2);
		chk(sleeping_q, 1);
		wdt_wake <= 1'b1;
		@(posedge clk_sys);
		wdt_wake <= 1'b0;
		#1;
		sync();
		chk(to_flag, 0);
		chk(sleeping_q, 0);
		// A wake that is not the watchdog must leave the time-out flag set
		run(16'h0003, 8'h00);
		chk(sleeping_q, 1);
		wake <= 1'b1;
		@(posedge clk_sys);
		wake <= 1'b0;
		#1;
		sync();
		chk(to_flag, 1);
		chk(sleeping_q, 0);
		$display("sleep test done");
		complete_run();
	end
endmodule : tb_rrse_exec
`default_nettype wire
